// ==== inc/acs_pkg.sv ====
// Constants, types and state encodings of the converter serial command port.
package acs_pkg;
    // Synchroniser plus edge-detect latency on the serial clock, in clk cycles.
    localparam int unsigned SYNC_LAT = 3;
    // Output release window after the last falling serial-clock edge, in clk cycles.
    localparam int unsigned DOUT_REL_MIN = 6;
    localparam int unsigned DOUT_REL_MAX = 10;
    localparam logic [3:0] DOUT_REL_CNT = 4'((DOUT_REL_MIN + DOUT_REL_MAX) / 2 - SYNC_LAT);
    // Least low time of the reset and restart pins, in clk cycles.
    localparam logic [2:0] PIN_PULSE_MIN = 3'h4;
    // Result update time during which the output word is invalid.
    localparam logic [4:0] UPDATE_CYC = 5'h10;
    // Serial-clock reset pattern windows, in clk cycles.
    localparam logic [10:0] PAT_H1_MIN = 11'h12c;
    localparam logic [10:0] PAT_H1_MAX = 11'h1f4;
    localparam logic [10:0] PAT_LOW_MIN = 11'h005;
    localparam logic [10:0] PAT_H2_MIN = 11'h226;
    localparam logic [10:0] PAT_H2_MAX = 11'h2ee;
    localparam logic [10:0] PAT_H3_MIN = 11'h41a;
    localparam logic [10:0] PAT_H3_MAX = 11'h4e2;
    localparam logic [10:0] PAT_CNT_MAX = 11'h7ff;
    // Configuration storage indexes.
    localparam int unsigned NUM_REGS = 5;
    localparam logic [2:0] REG_STATUS = 3'h0;
    localparam logic [2:0] REG_MUX = 3'h1;
    localparam logic [2:0] REG_ADCON = 3'h2;
    localparam logic [2:0] REG_DRATE = 3'h3;
    localparam logic [2:0] REG_IO = 3'h4;
    // Reset values.
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] MUX_RST = 8'h01;
    localparam logic [7:0] ADCON_RST = 8'h00;
    localparam logic [7:0] DRATE_RST = 8'h00;
    localparam logic [7:0] IO_RST = 8'hf0;
    // Field positions.
    localparam int unsigned STATUS_RDY_BIT = 0;
    localparam int unsigned STATUS_BUF_BIT = 1;
    localparam int unsigned MUX_NEG_LSB = 0;
    localparam int unsigned MUX_POS_LSB = 4;
    localparam int unsigned ADCON_GAIN_LSB = 0;
    localparam int unsigned ADCON_SENSE_LSB = 3;
    localparam int unsigned ADCON_CLKO_LSB = 5;
    localparam int unsigned IO_LVL_LSB = 0;
    localparam int unsigned IO_DIR_LSB = 4;
    localparam logic [2:0] GAIN_MAX = 3'h6;
    // Command codes.
    localparam logic [7:0] CMD_RDATA = 8'h10;
    localparam logic [7:0] CMD_CONTINUOUS_RESULT_READ_CMD = 8'h11;
    localparam logic [7:0] CMD_SDATAC = 8'h12;
    localparam logic [3:0] CMD_REGISTER_READ_CMD_PFX = 4'h2;
    localparam logic [3:0] CMD_REGISTER_WRITE_CMD_PFX = 4'h3;
    localparam logic [4:0] CMD_CAL_PFX = 5'h08;
    localparam logic [2:0] CAL_LAST = 3'h4;
    localparam logic [7:0] CMD_SYNC = 8'h50;
    localparam logic [7:0] CMD_STANDBY = 8'h51;
    localparam logic [7:0] CMD_RESET = 8'h52;
    localparam logic [7:0] CMD_WAKEUP = 8'h53;
    localparam logic [7:0] RES_LAST_BYTES = 8'h02;
    localparam int unsigned RES_W = 24;

    typedef enum logic [2:0] {PAT_H1, PAT_L1, PAT_H2, PAT_L2, PAT_H3} acs_pat_e;
    typedef enum logic [2:0] {SER_CMD, SER_RD_CNT, SER_WR_CNT, SER_WR_DATA, SER_OUT} acs_ser_e;

    typedef struct packed {
        logic buffer_en;
        logic [3:0] mux_pos;
        logic [3:0] mux_neg;
        logic [1:0] sensor_sel;
        logic [1:0] clock_output_pin_sel;
        logic [2:0] gain;
        logic [7:0] rate;
    } acs_cfg_s;
endpackage : acs_pkg

// ==== hw/acs_port.sv ====
// Serial command port, configuration storage and result path of the converter.
`timescale 1ns/1ps

module acs_port (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Serial port pins.
    input wire logic sclk,
    input wire logic din,
    input wire logic cs_n,
    output logic dout,
    output logic dout_oe_n,
    output logic conversion_ready_n,
    // Control pins.
    input wire logic reset_pin_n,
    input wire logic restart_powerdown_n,
    // General-purpose pins.
    input wire logic [3:0] gpio_in,
    output logic [3:0] gpio_out,
    output logic [3:0] gpio_oe_n,
    // Conversion result stream.
    input wire logic res_valid,
    output logic res_ready,
    input wire logic [acs_pkg::RES_W-1:0] res_data,
    // Converter control.
    output acs_pkg::acs_cfg_s cfg,
    output logic [6:0] gain_factor,
    output logic conv_restart,
    output logic cal_start,
    output logic [2:0] cal_kind,
    output logic standby
);
    import acs_pkg::*;

    logic [1:0] sclk_q, din_q, cs_q, rpin_q, spin_q;
    logic [3:0] gpio_q0, gpio_q1;
    logic sclk_d;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 2'h0;
            din_q <= 2'h0;
            cs_q <= 2'h3;
            rpin_q <= 2'h3;
            spin_q <= 2'h3;
            gpio_q0 <= 4'h0;
            gpio_q1 <= 4'h0;
            sclk_d <= 1'b0;
        end else begin
            sclk_q <= {sclk_q[0], sclk};
            din_q <= {din_q[0], din};
            cs_q <= {cs_q[0], cs_n};
            rpin_q <= {rpin_q[0], reset_pin_n};
            spin_q <= {spin_q[0], restart_powerdown_n};
            gpio_q0 <= gpio_in;
            gpio_q1 <= gpio_q0;
            sclk_d <= sclk_q[1];
        end
    end

    logic sclk_rise, sclk_fall, cs_act;
    assign sclk_rise = sclk_q[1] & ~sclk_d;
    assign sclk_fall = ~sclk_q[1] & sclk_d;
    assign cs_act = ~cs_q[1];

    // Pin pulse qualifiers: index 0 is the reset pin, index 1 the restart pin.
    logic [1:0] pin_lvl, pin_hit;
    assign pin_lvl = {spin_q[1], rpin_q[1]};
    for (genvar i = 0; i < 2; i++) begin : g_pin
        logic [2:0] cnt, next_cnt;
        always_comb begin
            next_cnt = cnt;
            if (pin_lvl[i]) begin
                next_cnt = 3'h0;
            end else if (cnt != PIN_PULSE_MIN) begin
                next_cnt = cnt + 3'h1;
            end
        end
        assign pin_hit[i] = (next_cnt == PIN_PULSE_MIN) && (cnt != PIN_PULSE_MIN);
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt <= 3'h0;
            end else begin
                cnt <= next_cnt;
            end
        end
    end

    function automatic logic in_win(input logic [10:0] v, input logic [10:0] lo, input logic [10:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction : in_win

    // Reset pattern detector; each edge restarts the pulse counter.
    acs_pat_e pat, next_pat;
    logic [10:0] pat_cnt, next_pat_cnt;
    logic pat_hit;
    always_comb begin
        next_pat = pat;
        next_pat_cnt = (pat_cnt == PAT_CNT_MAX) ? pat_cnt : pat_cnt + 11'h1;
        pat_hit = 1'b0;
        if (sclk_rise || sclk_fall) begin
            next_pat_cnt = 11'h001;
        end
        if (sclk_fall) begin
            unique case (pat)
                PAT_H1: next_pat = in_win(pat_cnt, PAT_H1_MIN, PAT_H1_MAX) ? PAT_L1 : PAT_H1;
                PAT_H2: next_pat = in_win(pat_cnt, PAT_H2_MIN, PAT_H2_MAX) ? PAT_L2 : PAT_H1;
                PAT_H3: begin
                    pat_hit = in_win(pat_cnt, PAT_H3_MIN, PAT_H3_MAX);
                    next_pat = PAT_H1;
                end
                default: next_pat = PAT_H1;
            endcase
        end else if (sclk_rise && (pat == PAT_L1 || pat == PAT_L2)) begin
            if (pat_cnt < PAT_LOW_MIN) begin
                next_pat = PAT_H1;
            end else begin
                next_pat = (pat == PAT_L1) ? PAT_H2 : PAT_H3;
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pat <= PAT_H1;
            pat_cnt <= 11'h000;
        end else begin
            pat <= next_pat;
            pat_cnt <= next_pat_cnt;
        end
    end

    logic cmd_rst, soft_rst, flush;
    assign soft_rst = pat_hit | pin_hit[0] | cmd_rst;
    assign flush = soft_rst | conv_restart | cal_start;

    // Two-entry result buffer and the result register behind it.
    logic [RES_W-1:0] fifo_mem [2];
    logic [RES_W-1:0] next_fifo_mem [2];
    logic fifo_wp, next_fifo_wp, fifo_rp, next_fifo_rp;
    logic [1:0] fifo_cnt, next_fifo_cnt;
    logic [RES_W-1:0] result, next_result;
    logic [4:0] upd_cnt, next_upd_cnt;
    logic rdy_n, next_rdy_n, res_take, out_res, push, pop, res_new;
    assign res_ready = (fifo_cnt != 2'h2) & ~flush;
    assign res_new = (upd_cnt == 5'h01);
    always_comb begin
        next_fifo_mem = fifo_mem;
        next_fifo_wp = fifo_wp;
        next_fifo_rp = fifo_rp;
        next_result = result;
        next_upd_cnt = upd_cnt;
        next_rdy_n = rdy_n;
        push = res_valid & res_ready;
        // A result being shifted out is never replaced, so the buffer fills instead.
        pop = (fifo_cnt != 2'h0) && (upd_cnt == 5'h00) && !out_res;
        if (push) begin
            next_fifo_mem[fifo_wp] = res_data;
            next_fifo_wp = ~fifo_wp;
        end
        if (pop) begin
            next_fifo_rp = ~fifo_rp;
            next_result = fifo_mem[fifo_rp];
            next_upd_cnt = UPDATE_CYC;
            next_rdy_n = 1'b1;
        end else if (upd_cnt != 5'h00) begin
            next_upd_cnt = upd_cnt - 5'h01;
            if (res_new) begin
                next_rdy_n = 1'b0;
            end
        end
        if (res_take) begin
            next_rdy_n = 1'b1;
        end
        next_fifo_cnt = fifo_cnt + {1'b0, push} - {1'b0, pop};
        if (flush) begin
            next_fifo_wp = 1'b0;
            next_fifo_rp = 1'b0;
            next_fifo_cnt = 2'h0;
            next_upd_cnt = 5'h00;
            next_rdy_n = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_mem[0] <= '0;
            fifo_mem[1] <= '0;
            fifo_wp <= 1'b0;
            fifo_rp <= 1'b0;
            fifo_cnt <= 2'h0;
            result <= '0;
            upd_cnt <= 5'h00;
            rdy_n <= 1'b1;
        end else begin
            fifo_mem <= next_fifo_mem;
            fifo_wp <= next_fifo_wp;
            fifo_rp <= next_fifo_rp;
            fifo_cnt <= next_fifo_cnt;
            result <= next_result;
            upd_cnt <= next_upd_cnt;
            rdy_n <= next_rdy_n;
        end
    end
    assign conversion_ready_n = rdy_n;

    // Configuration storage and its read view.
    logic [7:0] regs [NUM_REGS];
    logic [7:0] next_regs [NUM_REGS];
    logic [7:0] view [8];
    for (genvar i = 0; i < 8; i++) begin : g_view
        if (i == REG_STATUS) begin : g_st
            assign view[i] = {regs[i][7:1], rdy_n};
        end else if (i == REG_IO) begin : g_io
            assign view[i] = {regs[i][7:4], (regs[i][3:0] & ~regs[i][7:4]) | (gpio_q1 & regs[i][7:4])};
        end else if (i < NUM_REGS) begin : g_rw
            assign view[i] = regs[i];
        end else begin : g_zero
            assign view[i] = 8'h00;
        end
    end

    // Serial engine: data in on falling edges, data out on rising edges.
    acs_ser_e ser, next_ser;
    logic [2:0] bit_cnt, next_bit_cnt, reg_ptr, next_reg_ptr, next_cal_kind;
    logic [7:0] rx, next_rx, left, next_left, rx_byte;
    logic [RES_W-1:0] tx, next_tx;
    logic [3:0] rel_cnt, next_rel_cnt;
    logic next_dout, drive, next_drive, next_out_res, cont, next_cont, stby, next_stby;
    logic next_cal_start, next_conv_restart, next_cmd_rst, byte_done;
    always_comb begin
        next_ser = ser;
        next_bit_cnt = bit_cnt;
        next_reg_ptr = reg_ptr;
        next_rx = rx;
        next_left = left;
        next_tx = tx;
        next_rel_cnt = rel_cnt;
        next_dout = dout;
        next_drive = drive;
        next_out_res = out_res;
        next_cont = cont;
        next_stby = stby;
        next_regs = regs;
        next_cal_kind = cal_kind;
        next_cal_start = 1'b0;
        next_cmd_rst = 1'b0;
        next_conv_restart = pin_hit[1];
        res_take = 1'b0;
        byte_done = 1'b0;
        rx_byte = {rx[6:0], din_q[1]};
        if (!cs_act) begin
            next_bit_cnt = 3'h0;
            next_drive = 1'b0;
            next_ser = SER_CMD;
            next_out_res = 1'b0;
        end else if (sclk_fall) begin
            next_rx = rx_byte;
            next_bit_cnt = bit_cnt + 3'h1;
            byte_done = (bit_cnt == 3'h7);
        end
        if (cs_act && sclk_rise && drive) begin
            next_dout = tx[RES_W-1];
            next_tx = {tx[RES_W-2:0], 1'b0};
        end
        if (sclk_fall) begin
            next_rel_cnt = DOUT_REL_CNT;
        end else if (rel_cnt != 4'h0) begin
            next_rel_cnt = rel_cnt - 4'h1;
        end
        if (rel_cnt == 4'h1 && ser == SER_CMD) begin
            next_drive = 1'b0;
        end
        if (byte_done) begin
            unique case (ser)
                SER_CMD: begin
                    if (rx_byte == CMD_RDATA) begin
                        res_take = 1'b1;
                    end else if (rx_byte == CMD_CONTINUOUS_RESULT_READ_CMD) begin
                        next_cont = 1'b1;
                    end else if (rx_byte == CMD_SDATAC) begin
                        next_cont = 1'b0;
                    end else if (rx_byte[7:4] == CMD_REGISTER_READ_CMD_PFX) begin
                        next_reg_ptr = rx_byte[2:0];
                        next_ser = SER_RD_CNT;
                    end else if (rx_byte[7:4] == CMD_REGISTER_WRITE_CMD_PFX) begin
                        next_reg_ptr = rx_byte[2:0];
                        next_ser = SER_WR_CNT;
                    end else if (rx_byte == CMD_SYNC) begin
                        next_conv_restart = 1'b1;
                    end else if (rx_byte == CMD_STANDBY) begin
                        next_stby = 1'b1;
                    end else if (rx_byte == CMD_WAKEUP) begin
                        next_stby = 1'b0;
                        next_conv_restart = 1'b1;
                    end else if (rx_byte == CMD_RESET) begin
                        next_cmd_rst = 1'b1;
                    end else if (rx_byte[7:3] == CMD_CAL_PFX && rx_byte[2:0] <= CAL_LAST) begin
                        next_cal_start = 1'b1;
                        next_cal_kind = rx_byte[2:0];
                    end
                end
                SER_RD_CNT: begin
                    // The host's wait before clocking data leaves the word settled.
                    next_left = rx_byte;
                    next_tx = {view[reg_ptr], 16'h0000};
                    next_out_res = 1'b0;
                    next_drive = 1'b1;
                    next_ser = SER_OUT;
                end
                SER_WR_CNT: begin
                    next_left = rx_byte;
                    next_ser = SER_WR_DATA;
                end
                SER_WR_DATA: begin
                    if (reg_ptr < REG_IO + 3'h1) begin
                        next_regs[reg_ptr] = rx_byte;
                    end
                    next_reg_ptr = reg_ptr + 3'h1;
                    next_left = left - 8'h01;
                    if (left == 8'h00) begin
                        next_ser = SER_CMD;
                    end
                end
                SER_OUT: begin
                    if (left == 8'h00) begin
                        next_ser = SER_CMD;
                        next_out_res = 1'b0;
                    end else begin
                        next_left = left - 8'h01;
                        if (!out_res) begin
                            next_reg_ptr = reg_ptr + 3'h1;
                            next_tx = {view[3'(reg_ptr + 3'h1)], 16'h0000};
                        end
                    end
                end
            endcase
        end
        // An automatic load is not a read, so data-ready still falls for the host.
        if (res_take || (cont && ser == SER_CMD && !byte_done && res_new)) begin
            next_tx = result;
            next_left = RES_LAST_BYTES;
            next_out_res = 1'b1;
            next_drive = 1'b1;
            next_ser = SER_OUT;
        end
        if (soft_rst) begin
            next_ser = SER_CMD;
            next_bit_cnt = 3'h0;
            next_drive = 1'b0;
            next_out_res = 1'b0;
            next_cont = 1'b0;
            next_stby = 1'b0;
            next_regs = '{STATUS_RST, MUX_RST, ADCON_RST, DRATE_RST, IO_RST};
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ser <= SER_CMD;
            bit_cnt <= 3'h0;
            reg_ptr <= 3'h0;
            rx <= 8'h00;
            left <= 8'h00;
            tx <= '0;
            rel_cnt <= 4'h0;
            dout <= 1'b0;
            drive <= 1'b0;
            out_res <= 1'b0;
            cont <= 1'b0;
            stby <= 1'b0;
            regs <= '{STATUS_RST, MUX_RST, ADCON_RST, DRATE_RST, IO_RST};
            cal_kind <= 3'h0;
            cal_start <= 1'b0;
            cmd_rst <= 1'b0;
            conv_restart <= 1'b0;
        end else begin
            ser <= next_ser;
            bit_cnt <= next_bit_cnt;
            reg_ptr <= next_reg_ptr;
            rx <= next_rx;
            left <= next_left;
            tx <= next_tx;
            rel_cnt <= next_rel_cnt;
            dout <= next_dout;
            drive <= next_drive;
            out_res <= next_out_res;
            cont <= next_cont;
            stby <= next_stby;
            regs <= next_regs;
            cal_kind <= next_cal_kind;
            cal_start <= next_cal_start;
            cmd_rst <= next_cmd_rst;
            conv_restart <= next_conv_restart;
        end
    end
    // The raw select releases the pin at once; the engine itself only sees the synchronised one.
    assign dout_oe_n = ~(drive & cs_act & ~cs_n);

    assign cfg.buffer_en = regs[REG_STATUS][STATUS_BUF_BIT];
    assign cfg.mux_pos = regs[REG_MUX][MUX_POS_LSB +: 4];
    assign cfg.mux_neg = regs[REG_MUX][MUX_NEG_LSB +: 4];
    assign cfg.sensor_sel = regs[REG_ADCON][ADCON_SENSE_LSB +: 2];
    assign cfg.clock_output_pin_sel = regs[REG_ADCON][ADCON_CLKO_LSB +: 2];
    assign cfg.gain = regs[REG_ADCON][ADCON_GAIN_LSB +: 3];
    // The filter maps this code onto rates from 2.5 to 30k samples per second.
    assign cfg.rate = regs[REG_DRATE];

    // General pins, clock output and gain decode.
    logic [2:0] div, next_div, gsel;
    logic [3:0] next_gpio_out, next_gpio_oe_n;
    logic [6:0] next_gain;
    logic next_standby;
    always_comb begin
        next_div = div + 3'h1;
        next_gpio_out = regs[REG_IO][IO_LVL_LSB +: 4];
        next_gpio_oe_n = regs[REG_IO][IO_DIR_LSB +: 4];
        if (cfg.clock_output_pin_sel != 2'h0) begin
            next_gpio_out[0] = div[2'(cfg.clock_output_pin_sel - 2'h1)];
            next_gpio_oe_n[0] = 1'b0;
        end
        gsel = (cfg.gain > GAIN_MAX) ? GAIN_MAX : cfg.gain;
        next_gain = 7'h01 << gsel;
        next_standby = stby | ~spin_q[1];
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div <= 3'h0;
            gpio_out <= 4'h0;
            gpio_oe_n <= 4'hf;
            gain_factor <= 7'h01;
            standby <= 1'b0;
        end else begin
            div <= next_div;
            gpio_out <= next_gpio_out;
            gpio_oe_n <= next_gpio_oe_n;
            gain_factor <= next_gain;
            standby <= next_standby;
        end
    end
endmodule : acs_port

// ==== bench/acs_host.sv ====
// Host model that masters the serial command port.
`timescale 1ns/1ps
module acs_host (
    // Clock.
    input wire logic clk,
    // Serial pins.
    output logic sclk = 1'b0,
    output logic din = 1'b0,
    input wire logic dout
);
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : hold
    // A 200 ns high phase is 50 clk here, so bytes are slow but always legal.
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sclk = 1'b1;
            din = tx[i];
            hold(50);
            rx[i] = dout;
            sclk = 1'b0;
            hold(50);
        end
    endtask : xbyte
    task automatic pulse(input int n);
        sclk = 1'b1;
        hold(n);
        sclk = 1'b0;
        hold(10);
    endtask : pulse
endmodule : acs_host

// ==== bench/acs_port_props.sv ====
// Assertions on the ports of the converter serial command port.
`timescale 1ns/1ps
module acs_port_props import acs_pkg::*; (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Watched ports.
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic dout_oe_n,
    input wire logic conversion_ready_n,
    input wire logic reset_pin_n,
    input wire logic restart_powerdown_n,
    input wire logic [3:0] gpio_out,
    input wire acs_pkg::acs_cfg_s cfg,
    input wire logic [6:0] gain_factor,
    input wire logic conv_restart,
    input wire logic standby
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_cs_release: assert property (cs_n |-> dout_oe_n) else $error("dout not released");
    a_dout_release: assert property ($rose(dout_oe_n) |-> cs_n || (!$past(sclk, 5) && $past(sclk, 11)))
        else $error("dout release out of window");
    a_update_gap: assert property ($fell(conversion_ready_n) |-> $past(conversion_ready_n, 16))
        else $error("result update too short");
    a_gain_map: assert property ($stable(cfg.gain) [*2] |->
        gain_factor == 7'(7'h01 << (cfg.gain > GAIN_MAX ? GAIN_MAX : cfg.gain))) else $error("gain factor wrong");
    a_pin_reset: assert property ((!reset_pin_n) [*6] |=> cfg.rate == DRATE_RST && conversion_ready_n)
        else $error("reset pin ignored");
    a_pin_standby: assert property ((!restart_powerdown_n) [*6] |-> standby) else $error("standby not held");
    a_restart_pulse: assert property ($fell(restart_powerdown_n) ##1 (!restart_powerdown_n) [*3] |-> ##[0:6] conv_restart)
        else $error("restart pulse missing");
    a_clock_output_pin_toggle: assert property ((cfg.clock_output_pin_sel == 2'h1) [*3] |-> gpio_out[0] != $past(gpio_out[0]))
        else $error("clock output stalled");
endmodule : acs_port_props
bind acs_port acs_port_props acs_port_props_inst (.clk, .rst_n, .sclk, .cs_n, .dout_oe_n, .conversion_ready_n,
    .reset_pin_n, .restart_powerdown_n, .gpio_out, .cfg, .gain_factor, .conv_restart, .standby);

// ==== bench/acs_port_tb.sv ====
// Self-checking testbench of the converter serial command port.
`timescale 1ns/1ps
module acs_port_tb;
    import acs_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, reset_pin_n = 1'b1, restart_powerdown_n = 1'b1, res_valid = 1'b0, cs_n = 1'b0;
    logic sclk, din, dout, dout_oe_n, conversion_ready_n, res_ready, standby, conv_restart, cal_start;
    logic [3:0] gpio_in = 4'ha, gpio_out, gpio_oe_n;
    logic [2:0] cal_kind;
    logic [23:0] res_data = 24'h000000;
    logic [7:0] rx;
    logic [6:0] gain_factor;
    acs_cfg_s cfg;
    int miscompares = 0, n_checks = 0, cycles = 0, n_pulse = 0;
    acs_port acs_port_inst (.clk, .rst_n, .sclk, .din, .cs_n, .dout, .dout_oe_n, .conversion_ready_n,
        .reset_pin_n, .restart_powerdown_n, .gpio_in, .gpio_out, .gpio_oe_n, .res_valid, .res_ready,
        .res_data, .cfg, .gain_factor, .conv_restart, .cal_start, .cal_kind, .standby);
    acs_host acs_host_inst (.clk, .sclk, .din, .dout);
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        if (++cycles == 70000) begin
            miscompares++;
            test_done();
        end
    end
    // Each pulse stands one cycle, so it is counted at the edge after its launch.
    always @(posedge clk) begin
        if (cal_start) n_pulse++;
        if (conv_restart) n_pulse++;
    end
    task automatic xb(input logic [7:0] b);
        acs_host_inst.xbyte(b, rx);
    endtask : xb
    task automatic push(input logic [23:0] d);
        res_valid = 1'b1;
        res_data = d;
        acs_host_inst.hold(1);
        res_valid = 1'b0;
        acs_host_inst.hold(1);
        while (conversion_ready_n !== 1'b0) acs_host_inst.hold(1);
    endtask : push
    task automatic test_cmds();
        xb({CMD_REGISTER_WRITE_CMD_PFX, 1'b0, REG_STATUS});
        xb(8'h04);
        for (int i = 4; i >= 0; i--) begin
            xb(8'(40'h027300a535 >> (8 * i)));
        end
        check({cfg.mux_pos, cfg.mux_neg, cfg.rate, gpio_out, gpio_oe_n}, 24'h73a553);
        check(cfg.buffer_en, 1'b1);
        xb({CMD_REGISTER_READ_CMD_PFX, 1'b0, REG_DRATE});
        xb(8'h01);
        xb(8'h00);
        check(rx, 8'ha5);
        xb(8'h00);
        check(rx, 8'h36);
        xb({CMD_REGISTER_READ_CMD_PFX, 1'b0, REG_DRATE});
        xb(8'h00);
        check(dout_oe_n, 1'b0);
        cs_n = 1'b1;
        acs_host_inst.hold(1);
        check(dout_oe_n, 1'b1);
        acs_host_inst.hold(8);
        cs_n = 1'b0;
        acs_host_inst.hold(4);
        check(dout_oe_n, 1'b1);
        xb({CMD_CAL_PFX, 3'h2});
        check({cal_kind, conversion_ready_n}, {3'h2, 1'b1});
        push(24'h123456);
        xb(CMD_STANDBY);
        check(standby, 1'b1);
        push(24'h654321);
        xb(CMD_WAKEUP);
        check(standby, 1'b0);
        xb(CMD_SYNC);
        xb(CMD_CONTINUOUS_RESULT_READ_CMD);
        push(24'h5a3c96);
        for (int i = 2; i >= 0; i--) begin
            xb(8'h00);
            check(rx, 8'(24'h5a3c96 >> (8 * i)));
        end
        xb(CMD_SDATAC);
        check(24'(n_pulse), 24'h000004);
        xb(CMD_RESET);
        check(cfg.rate, DRATE_RST);
    endtask : test_cmds
    task automatic wr(input logic [2:0] idx, input logic [7:0] val);
        acs_host_inst.xbyte({CMD_REGISTER_WRITE_CMD_PFX, 1'b0, idx}, rx);
        acs_host_inst.xbyte(8'h00, rx);
        acs_host_inst.xbyte(val, rx);
    endtask : wr
    task automatic test_gain();
        for (int i = 0; i < 8; i++) begin
            wr(REG_ADCON, 8'h30 | 8'(i));
            check({cfg.sensor_sel, cfg.clock_output_pin_sel, cfg.gain, gain_factor}, {4'h9, 3'(i), 7'(1 << (i > 6 ? 6 : i))});
        end
    endtask : test_gain
    // Three words back to back fill the two-entry buffer while the first update runs.
    task automatic test_result();
        for (int k = 1; k < 4; k++) begin
            res_valid = 1'b1;
            res_data = 24'(k * 24'h150a05);
            while (res_ready !== 1'b1) acs_host_inst.hold(1);
            acs_host_inst.hold(1);
        end
        check(res_ready, 1'b0);
        res_valid = 1'b0;
        acs_host_inst.hold(100);
        check(conversion_ready_n, 1'b0);
        acs_host_inst.xbyte(CMD_RDATA, rx);
        for (int i = 2; i >= 0; i--) begin
            acs_host_inst.xbyte(8'h00, rx);
            check(rx, 8'(24'h3f1e0f >> (8 * i)));
        end
        check(conversion_ready_n, 1'b1);
    endtask : test_result
    task automatic test_reset();
        wr(REG_DRATE, 8'hf0);
        acs_host_inst.pulse(400);
        acs_host_inst.pulse(650);
        acs_host_inst.pulse(1150);
        check(cfg.rate, DRATE_RST);
        wr(REG_DRATE, 8'hf0);
        reset_pin_n = 1'b0;
        restart_powerdown_n = 1'b0;
        acs_host_inst.hold(6);
        check({cfg.rate, standby}, {DRATE_RST, 1'b1});
        reset_pin_n = 1'b1;
        restart_powerdown_n = 1'b1;
    endtask : test_reset
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1'b1;
        acs_host_inst.hold(4);
        test_gain();
        test_result();
        test_reset();
        test_cmds();
        test_done();
    end
endmodule : acs_port_tb
